// ===== hw/scbd_pkg.sv
package scbd_pkg;

    // ------------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------------
    localparam int CMD_BITS = 8;
    localparam int CMD_START_BIT = 7;
    localparam int CMD_DIR_BIT = 6;
    localparam int SEL_BITS = 6;
    localparam int BANK_MSB = 5;
    localparam int BANK_LSB = 3;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic CMD_START_OK = 1'b0;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // ------------------------------------------------------------------
    // Register selector codes
    // ------------------------------------------------------------------
    localparam logic [5:0] SEL_STATUS = 6'h00;
    localparam logic [5:0] SEL_CONV_MODE = 6'h01;
    localparam logic [5:0] SEL_IF_MODE = 6'h02;
    localparam logic [5:0] SEL_REG_CHECK = 6'h03;
    localparam logic [5:0] SEL_CONV_DATA = 6'h04;
    localparam logic [5:0] SEL_PIN_CFG = 6'h06;
    localparam logic [5:0] SEL_IDENT = 6'h07;
    localparam logic [2:0] BANK_CHANNEL = 3'h2;
    localparam logic [2:0] BANK_SETUP = 3'h4;
    localparam logic [2:0] BANK_FILTER = 3'h5;
    localparam logic [2:0] BANK_OFFSET = 3'h6;
    localparam logic [2:0] BANK_GAIN = 3'h7;

    // ------------------------------------------------------------------
    // Register widths in bytes
    // ------------------------------------------------------------------
    localparam logic [1:0] BYTES_1 = 2'h1;
    localparam logic [1:0] BYTES_2 = 2'h2;
    localparam logic [1:0] BYTES_3 = 2'h3;
    localparam int DATA_BITS = 24;

    // ------------------------------------------------------------------
    // Transaction states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_LOAD = 3'b010,
        ST_DATA = 3'b011,
        ST_SKIP = 3'b100
    } scbd_state_t;

endpackage

// ===== hw/scbd_dec_if.sv
`timescale 1ns/1ps
interface scbd_dec_if;
    logic [5:0] sel;
    logic [1:0] nbytes;
    logic known;

    modport decoder (
        input sel,
        output nbytes,
        output known
    );

    modport user (
        output sel,
        input nbytes,
        input known
    );
endinterface

// ===== hw/scbd_sel_decode.sv
`timescale 1ns/1ps
module scbd_sel_decode (
    // Selector in, width out
    scbd_dec_if.decoder dec
);
    import scbd_pkg::*;

    // ------------------------------------------------------------------
    // Selector to register width
    // ------------------------------------------------------------------
    always_comb begin
        dec.nbytes = BYTES_1;
        dec.known = 1'b1;
        case (dec.sel[BANK_MSB:BANK_LSB])
            3'h0: begin
                case (dec.sel)
                    SEL_STATUS: dec.nbytes = BYTES_1;
                    SEL_CONV_MODE: dec.nbytes = BYTES_2;
                    SEL_IF_MODE: dec.nbytes = BYTES_2;
                    SEL_REG_CHECK: dec.nbytes = BYTES_3;
                    SEL_CONV_DATA: dec.nbytes = BYTES_3;
                    SEL_PIN_CFG: dec.nbytes = BYTES_2;
                    SEL_IDENT: dec.nbytes = BYTES_2;
                    default: dec.known = 1'b0;
                endcase
            end
            // Upper three bits are the bank index, width is per bank
            BANK_CHANNEL: dec.nbytes = BYTES_2;
            BANK_SETUP: dec.nbytes = BYTES_2;
            BANK_FILTER: dec.nbytes = BYTES_2;
            BANK_OFFSET: dec.nbytes = BYTES_3;
            BANK_GAIN: dec.nbytes = BYTES_3;
            default: dec.known = 1'b0;
        endcase
    end

endmodule // scbd_sel_decode

// ===== hw/scbd_top.sv
`timescale 1ns/1ps
// Behaviour
// - Bit 6 of the command byte picks write when 0 and read when 1.
// - Bits 5 to 0 select the register used by this transaction.
// - Global registers sit at selector codes 0 to 4, 6 and 7.
// - Per-channel banks take eight codes each, low bits the index.
module scbd_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Serial link pins
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_EN_N,
    // Register side
    output logic CMD_VALID,
    output logic CMD_READ,
    output logic [5:0] CMD_SEL,
    output logic [1:0] CMD_NBYTES,
    input wire logic [scbd_pkg::DATA_BITS-1:0] RD_DATA,
    output logic [scbd_pkg::DATA_BITS-1:0] WR_DATA,
    output logic WR_STROBE,
    output logic BAD_SELECT
);
    import scbd_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        scbd_state_t st;
        logic [2:0] bit_cnt;
        logic [1:0] bytes_left;
        logic [7:0] cmd_shift;
        logic [7:0] cmd;
        logic [1:0] nbytes;
        logic [DATA_BITS-1:0] in_shift;
        logic [DATA_BITS-1:0] out_shift;
        logic dout;
        logic dout_en_n;
        logic cmd_valid;
        logic wr_strobe;
        logic [DATA_BITS-1:0] wr_data;
        logic bad_select;
    } scbd_regs_t;

    scbd_regs_t r_q;
    scbd_regs_t r_d;

    scbd_dec_if dec_bus ();

    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic din_bit;
    logic [7:0] cmd_next;
    logic [DATA_BITS-1:0] in_next;
    logic byte_done;

    // ------------------------------------------------------------------
    // Width lookup
    // ------------------------------------------------------------------
    // Decoding the stored byte keeps the lookup off the sampling path
    assign dec_bus.sel = r_q.cmd[SEL_BITS-1:0];

    scbd_sel_decode u_decode (
        .dec(dec_bus)
    );

    // ------------------------------------------------------------------
    // Pin edges
    // ------------------------------------------------------------------
    // Edges only from the second and third stages, never the first
    assign sclk_rise = r_q.sclk_s[1] & ~r_q.sclk_s[2];
    assign sclk_fall = ~r_q.sclk_s[1] & r_q.sclk_s[2];
    assign cs_active = ~r_q.cs_s[1];
    assign din_bit = r_q.din_s[1];
    assign cmd_next = {r_q.cmd_shift[6:0], din_bit};
    assign in_next = {r_q.in_shift[DATA_BITS-2:0], din_bit};
    assign byte_done = (r_q.bit_cnt == 3'h7);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.sclk_s = {r_q.sclk_s[1:0], SCLK};
        r_d.cs_s = {r_q.cs_s[0], CS_N};
        r_d.din_s = {r_q.din_s[0], DIN};
        r_d.cmd_valid = 1'b0;
        r_d.wr_strobe = 1'b0;
        if (!cs_active) begin
            // Deselect aborts anything in progress
            r_d.st = ST_IDLE;
            r_d.bit_cnt = 3'h0;
            r_d.dout_en_n = 1'b1;
        end else begin
            case (r_q.st)
                ST_IDLE: begin
                    r_d.st = ST_CMD;
                    r_d.bit_cnt = 3'h0;
                end
                ST_CMD: begin
                    if (sclk_rise) begin
                        r_d.cmd_shift = cmd_next;
                        r_d.bit_cnt = r_q.bit_cnt + 3'h1;
                        if (byte_done) begin
                            // A byte with the top bit set is dropped
                            if (cmd_next[CMD_START_BIT] == CMD_START_OK) begin
                                r_d.cmd = cmd_next;
                                r_d.st = ST_LOAD;
                            end
                        end
                    end
                end
                ST_LOAD: begin
                    r_d.cmd_valid = 1'b1;
                    r_d.nbytes = dec_bus.nbytes;
                    r_d.bad_select = ~dec_bus.known;
                    r_d.bit_cnt = 3'h0;
                    r_d.in_shift = '0;
                    r_d.bytes_left = dec_bus.nbytes - BYTES_1;
                    // Left-align so the first bit out is the register MSB
                    case (dec_bus.nbytes)
                        BYTES_1: r_d.out_shift = {RD_DATA[7:0], 16'h0000};
                        BYTES_2: r_d.out_shift = {RD_DATA[15:0], 8'h00};
                        default: r_d.out_shift = RD_DATA;
                    endcase
                    if (!dec_bus.known) begin
                        // Unknown selector: no data phase this frame
                        r_d.st = ST_SKIP;
                    end else begin
                        r_d.st = ST_DATA;
                        if (r_q.cmd[CMD_DIR_BIT] == DIR_READ) begin
                            r_d.dout_en_n = 1'b0;
                            r_d.dout = r_d.out_shift[DATA_BITS-1];
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_fall && !r_q.dout_en_n) begin
                        r_d.dout = r_q.out_shift[DATA_BITS-1];
                    end
                    if (sclk_rise) begin
                        r_d.in_shift = in_next;
                        r_d.out_shift = {r_q.out_shift[DATA_BITS-2:0], 1'b0};
                        r_d.bit_cnt = r_q.bit_cnt + 3'h1;
                        if (byte_done) begin
                            if (r_q.bytes_left == 2'h0) begin
                                // Count reached: back to the command byte
                                r_d.st = ST_CMD;
                                r_d.dout_en_n = 1'b1;
                                r_d.cmd_shift = CMD_RESET;
                                if (r_q.cmd[CMD_DIR_BIT] == DIR_WRITE) begin
                                    r_d.wr_data = in_next;
                                    r_d.wr_strobe = 1'b1;
                                end
                            end else begin
                                r_d.bytes_left = r_q.bytes_left - 2'h1;
                            end
                        end
                    end
                end
                ST_SKIP: begin
                    r_d.dout_en_n = 1'b1;
                end
                default: begin
                    r_d.st = ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            r_q.sclk_s <= 3'h7;
            r_q.cs_s <= 2'h3;
            r_q.din_s <= 2'h0;
            r_q.st <= ST_IDLE;
            r_q.bit_cnt <= 3'h0;
            r_q.bytes_left <= 2'h0;
            r_q.cmd_shift <= CMD_RESET;
            r_q.cmd <= CMD_RESET;
            r_q.nbytes <= 2'h0;
            r_q.in_shift <= '0;
            r_q.out_shift <= '0;
            r_q.dout <= 1'b0;
            r_q.dout_en_n <= 1'b1;
            r_q.cmd_valid <= 1'b0;
            r_q.wr_strobe <= 1'b0;
            r_q.wr_data <= '0;
            r_q.bad_select <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign DOUT = r_q.dout;
    assign DOUT_EN_N = r_q.dout_en_n;
    assign CMD_VALID = r_q.cmd_valid;
    assign CMD_READ = r_q.cmd[CMD_DIR_BIT];
    assign CMD_SEL = r_q.cmd[SEL_BITS-1:0];
    assign CMD_NBYTES = r_q.nbytes;
    assign WR_DATA = r_q.wr_data;
    assign WR_STROBE = r_q.wr_strobe;
    assign BAD_SELECT = r_q.bad_select;

endmodule // scbd_top

// ===== testbench/scbd_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module scbd_properties
    import scbd_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Watched outputs
    input wire logic DOUT_EN_N,
    input wire logic CMD_VALID,
    input wire logic CMD_READ,
    input wire logic [5:0] CMD_SEL,
    input wire logic [1:0] CMD_NBYTES,
    input wire logic WR_STROBE,
    input wire logic BAD_SELECT
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    sequence read_open;
        $fell(DOUT_EN_N);
    endsequence
    sequence read_cmd;
        CMD_VALID && CMD_READ;
    endsequence
    a_valid_pulse: assert property (
        CMD_VALID |=> !CMD_VALID) else $error("command pulse too long");
    a_read_open: assert property (
        read_open |-> read_cmd) else $error("enable without read command");
    a_write_quiet: assert property (
        CMD_VALID && !CMD_READ |-> DOUT_EN_N) else $error("write drove out");
    a_sel_hold: assert property (
        $changed(CMD_SEL) |=> CMD_VALID) else $error("selector moved alone");
    a_status_one: assert property (
        CMD_VALID && CMD_SEL == SEL_STATUS |-> CMD_NBYTES == BYTES_1)
        else $error("status width wrong");
    a_bank_wide: assert property (
        CMD_VALID && CMD_SEL[5:4] == 2'h3 |-> CMD_NBYTES == BYTES_3)
        else $error("offset or gain width wrong");
    a_bad_flag: assert property (
        CMD_VALID && (CMD_SEL == 6'h05 || CMD_SEL[5:3] == 3'h1)
        |-> ##[0:2] BAD_SELECT) else $error("unmapped code not flagged");
    a_strobe_idle: assert property (
        !DOUT_EN_N |-> !WR_STROBE) else $error("strobe during read");
    a_strobe_pulse: assert property (
        WR_STROBE |=> !WR_STROBE) else $error("strobe too long");
endmodule // scbd_properties

bind scbd_top scbd_properties u_props (.CLK_SYS, .RSTN, .DOUT_EN_N,
    .CMD_VALID, .CMD_READ, .CMD_SEL, .CMD_NBYTES, .WR_STROBE, .BAD_SELECT);

// ===== testbench/scbd_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side of the serial link
// ------------------------------------------------------------
module scbd_host (
    // Serial link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    task automatic frame_start;
        #1.25;
        cs_n = 1'b0;
        #98.75;
    endtask
    // Released data line flips so a stale bit never reads as valid
    task automatic frame_end;
        #101.25;
        cs_n = 1'b1;
        din = ~din;
        #298.75;
    endtask
    // Clock stands high outside bytes; bit out on fall, in on rise
    task automatic xfer(input logic [7:0] tx,
                        output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            // Off the system clock grid, so no pin moves on its edge
            #1.25;
            sclk = 1'b0;
            din = tx[i];
            #62.5;
            sclk = 1'b1;
            rx[i] = dout;
            #61.25;
        end
    endtask
endmodule // scbd_host

// ===== testbench/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Command decoder bench
// ------------------------------------------------------------
module testbench;
    import scbd_pkg::*;
    logic clk, rstn, sclk, cs_n, din, dout, dout_en_n, cmd_valid, cmd_read;
    logic wr_strobe, bad_select, last_read, en_seen;
    logic [5:0] cmd_sel, last_sel;
    logic [1:0] cmd_nbytes, last_nb;
    logic [23:0] rd_data, wr_data;
    logic [7:0] rx;
    int err_count, num_checks, vcnt, scnt, cyc;
    logic [7:0] codes [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
        8'h07, 8'h10, 8'h17, 8'h27, 8'h28, 8'h30, 8'h3F};
    int widths [13] = '{1, 2, 2, 3, 3, 2, 2, 2, 2, 2, 2, 3, 3};
    logic [7:0] pat [3] = '{8'hA5, 8'h5A, 8'hC3};
    logic [7:0] bads [3] = '{8'h05, 8'h18, 8'h0B};

    scbd_top dut (.CLK_SYS(clk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n),
        .DIN(din), .DOUT(dout), .DOUT_EN_N(dout_en_n),
        .CMD_VALID(cmd_valid), .CMD_READ(cmd_read), .CMD_SEL(cmd_sel),
        .CMD_NBYTES(cmd_nbytes), .RD_DATA(rd_data), .WR_DATA(wr_data),
        .WR_STROBE(wr_strobe), .BAD_SELECT(bad_select));
    // Released data line shows the inverse, so a late enable is caught
    scbd_host host (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout_en_n ? ~dout : dout));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) begin
            vcnt <= vcnt + 1;
            last_sel <= cmd_sel;
            last_read <= cmd_read;
            last_nb <= cmd_nbytes;
        end
        if (wr_strobe === 1'b1) scnt <= scnt + 1;
        if (dout_en_n === 1'b0) en_seen <= 1'b1;
        if (cyc == 30000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, got);
        num_checks++;
        if (got !== e) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, e, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Command, then exactly n bytes; strobe only after the last one
    task automatic cmd_wr(input logic [7:0] c, input int n);
        logic [23:0] e;
        int s0;
        s0 = scnt;
        e = 24'h000000;
        host.xfer(c, rx);
        chk("selector", 24'(c[5:0]), 24'(last_sel));
        chk("direction", 24'h0, 24'(last_read));
        chk("width", 24'(n), 24'(last_nb));
        for (int i = 0; i < n; i++) begin
            chk("early strobe", 24'(s0), 24'(scnt));
            host.xfer(pat[i], rx);
            e = {e[15:0], pat[i]};
        end
        repeat (8) @(posedge clk);
        chk("strobes", 24'(s0 + 1), 24'(scnt));
        chk("write data", e, wr_data);
    endtask
    task automatic rd(input logic [7:0] c, input int n, input logic [23:0] e);
        logic [23:0] acc;
        int s0;
        s0 = scnt;
        acc = 24'h000000;
        en_seen = 1'b0;
        host.xfer(c, rx);
        chk("read direction", 24'h1, 24'(last_read));
        chk("read width", 24'(n), 24'(last_nb));
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h00, rx);
            acc = {acc[15:0], rx};
        end
        repeat (8) @(posedge clk);
        chk("read data", e, acc);
        chk("read enable", 24'h1, 24'(en_seen));
        chk("enable after", 24'h1, 24'(dout_en_n));
        chk("read strobes", 24'(s0), 24'(scnt));
    endtask

    initial begin
        rstn = 1'b0;
        rd_data = 24'hABCDEF;
        en_seen = 1'b0;
        repeat (15) @(posedge clk);
        chk("reset enable", 24'h1, 24'(dout_en_n));
        chk("reset flag", 24'h0, 24'(bad_select));
        chk("reset data", 24'h0, wr_data);
        @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        host.frame_start();
        foreach (codes[k]) cmd_wr(codes[k], widths[k]);
        host.frame_end();
        $display("write decode test done");
        host.frame_start();
        rd(8'h47, 2, 24'h00CDEF);
        rd(8'h44, 3, 24'hABCDEF);
        rd(8'h40, 1, 24'h0000EF);
        host.frame_end();
        $display("read test done");
        host.frame_start();
        vcnt = 0;
        host.xfer(8'h81, rx);
        chk("refused command", 24'h0, 24'(vcnt));
        cmd_wr(8'h01, 2);
        host.frame_end();
        $display("start bit test done");
        foreach (bads[k]) begin
            host.frame_start();
            scnt = 0;
            host.xfer(bads[k], rx);
            host.xfer(8'h01, rx);
            host.xfer(8'h12, rx);
            chk("bad flag", 24'h1, 24'(bad_select));
            chk("bad strobes", 24'h0, 24'(scnt));
            host.frame_end();
        end
        host.frame_start();
        cmd_wr(8'h02, 2);
        chk("flag cleared", 24'h0, 24'(bad_select));
        scnt = 0;
        host.xfer(8'h30, rx);
        host.xfer(8'h11, rx);
        host.frame_end();
        chk("abort strobes", 24'h0, 24'(scnt));
        $display("unmapped and abort test done");
        end_sim();
    end
endmodule // testbench
